// ==== hw/dccw_pkg.sv ====
// Purpose: Shared constants for the clock and wake-up control block.
// Assumes: APB byte addresses, one 32-bit word per register.
// Notes:   Ratios are stored as value minus one in four bits.
package dccw_pkg;

  // ==========================================================================
  // Register map
  localparam logic [7:0]  DCCW_OFS_CTRL     = 8'h00;
  localparam logic [7:0]  DCCW_OFS_CMD      = 8'h04;
  localparam logic [7:0]  DCCW_OFS_STAT     = 8'h08;

  // ==========================================================================
  // Control fields
  localparam int          DCCW_CTRL_M_LSB   = 0;
  localparam int          DCCW_CTRL_N_LSB   = 4;
  localparam int          DCCW_CTRL_L_LSB   = 8;
  localparam int          DCCW_CTRL_SYSTEM_CLOCK_OUTPUT_PIN  = 12;
  localparam int          DCCW_CTRL_WAKE    = 13;
  localparam int          DCCW_CTRL_HALT    = 14;
  localparam int          DCCW_CTRL_PORTSEL = 15;
  localparam int          DCCW_CTRL_INIT    = 16;
  localparam int          DCCW_CTRL_W       = 17;
  localparam int          DCCW_CMD_STOP     = 0;
  localparam logic [16:0] DCCW_CTRL_RST     = 17'h03000;

  // ==========================================================================
  // Status fields
  localparam int          DCCW_ST_STOP      = 0;
  localparam int          DCCW_ST_HALT      = 1;
  localparam int          DCCW_ST_LOCK      = 2;
  localparam int          DCCW_ST_MULT_LSB  = 4;
  localparam int          DCCW_ST_PORT2     = 8;
  localparam int          DCCW_ST_PORT3     = 9;

  // ==========================================================================
  // Fixed ratios of the pin-configured variant, minus one
  localparam logic [3:0]  DCCW_PIN_N_M1     = 4'h0;
  localparam logic [3:0]  DCCW_PIN_L_M1     = 4'h7;
  localparam logic [2:0]  DCCW_PIN_MULT_RST = 3'h0;

  typedef enum logic [2:0] {
    DCCW_RUN  = 3'b001,
    DCCW_HALT = 3'b010,
    DCCW_STOP = 3'b100
  } dccw_mode_t;

endpackage

// ==== hw/dccw_clk_if.sv ====
// Purpose: Carries one clock stage's tick and level between stages.
// Assumes: tick is high one core_clk cycle per stage clock period.
// Notes:   level is the stage's waveform as seen on the clock pin.
`timescale 1ns/100ps
interface dccw_clk_if;
  logic tick;
  logic level;
  modport src (output tick, output level);
  modport snk (input tick, input level);
endinterface

// ==== hw/dccw_pll_rate.sv ====
// Purpose: Multiplier stage, m ticks per reference clock period.
// Assumes: The reference input is synchronous and slower than core_clk / m.
// Notes:   A rate accumulator stands in for the oscillator of a real loop.
`timescale 1ns/100ps
module dccw_pll_rate
  import dccw_pkg::*;
#(
  parameter int CNT_W = 16
)(
  input  wire logic       core_clk,
  input  wire logic       srst,
  input  wire logic       ext_clk_in,
  input  wire logic       stopped,
  input  wire logic [3:0] mult_m1,
  output logic            locked,
  dccw_clk_if.src         pll_out
);

  logic             ref_d_ff;
  logic [CNT_W-1:0] per_cnt_ff;
  logic [CNT_W-1:0] period_ff;
  logic [CNT_W:0]   acc_ff;
  logic             lock_ff;
  logic             seen_ff;
  logic [CNT_W:0]   acc_sum;
  logic             ref_rise;
  logic             hit;

  assign ref_rise = ext_clk_in & ~ref_d_ff;
  assign acc_sum  = acc_ff + {{(CNT_W-4){1'b0}}, 1'b0, mult_m1} + {{CNT_W{1'b0}}, 1'b1};
  assign hit      = lock_ff & ~stopped & (acc_sum >= {1'b0, period_ff});
  assign pll_out.tick  = hit; // R03
  assign pll_out.level = hit;
  assign locked        = lock_ff;

  // ==========================================================================
  // Period measurement and rate accumulator, both frozen while stopped
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      ref_d_ff   <= 1'b1;
      per_cnt_ff <= '0;
      period_ff  <= '0;
      lock_ff    <= 1'b0;
      seen_ff    <= 1'b0;
      acc_ff     <= '0;
    end
    else if (!stopped)
    begin
      ref_d_ff   <= ext_clk_in;
      per_cnt_ff <= ref_rise ? '0 : per_cnt_ff + 1'b1;
      if (ref_rise)
      begin
        // The first rise only starts the count; lock waits for a full period.
        period_ff <= per_cnt_ff + 1'b1;
        seen_ff   <= 1'b1;
        lock_ff   <= seen_ff;
      end
      if (lock_ff)
        acc_ff <= hit ? acc_sum - {1'b0, period_ff} : acc_sum;
    end
  end

endmodule

// ==== hw/dccw_divider.sv ====
// Purpose: Integer clock divider, ratio 1 to 16, with bypass and freeze.
// Assumes: ratio_m1 may change at any time; the period in which it changes is irregular.
// Notes:   Odd ratios above one give a high phase of one input period.
`timescale 1ns/100ps
module dccw_divider
  import dccw_pkg::*;
(
  input  wire logic       core_clk,
  input  wire logic       srst,
  input  wire logic       freeze,
  input  wire logic       bypass,
  input  wire logic [3:0] ratio_m1,
  dccw_clk_if.snk         div_in,
  dccw_clk_if.src         div_out
);

  logic [3:0] cnt_ff;
  logic       level_ff;
  logic       last;
  logic       odd_ratio;
  logic       nxt_level;
  logic [3:0] nxt_cnt;
  logic [4:0] half;

  // A counter left above a newly lowered ratio wraps at the next tick instead of
  // running round all sixteen states.
  assign last      = (cnt_ff >= ratio_m1);
  assign odd_ratio = ~ratio_m1[0] & (ratio_m1 != 4'h0);
  assign half      = ({1'b0, ratio_m1} + 5'h01) >> 1;
  assign nxt_cnt   = (div_in.tick & ~freeze) ? (last ? 4'h0 : cnt_ff + 4'h1) : cnt_ff;
  assign nxt_level = (ratio_m1 == 4'h0) ? div_in.tick :
                     odd_ratio ? (nxt_cnt == 4'h0) : // R07
                     ({1'b0, nxt_cnt} < half);
  assign div_out.tick  = bypass ? div_in.tick : (div_in.tick & last & ~freeze); // R04 R05
  assign div_out.level = bypass ? div_in.level : level_ff;

  always_ff @(posedge core_clk)
  begin
    if (srst || bypass)
    begin
      cnt_ff   <= 4'h0;
      level_ff <= 1'b0;
    end
    else if (!freeze)
    begin
      cnt_ff   <= nxt_cnt;
      level_ff <= nxt_level;
    end
  end

  // ==========================================================================
  // Checks
  a_odd_high_one: assert property (@(posedge core_clk) disable iff (srst) // R07
    (!bypass && !freeze && odd_ratio && level_ff && div_in.tick) |=> !level_ff)
    else $error("odd ratio high phase exceeded one input period");

endmodule

// ==== hw/dccw_top.sv ====
// Purpose: Clock generation and stop/halt/wake control with an APB port.
// Assumes: core_clk is faster than the multiplied clock; pins synchronous.
// Notes:   The internal clock is a one-cycle tick; the pin gets its level.
// What this block does
// (R01) Normal clock is input times m over n.
// (R02) Halt clock is normal clock divided by l.
// (R03) Multiplier stage scales reference by 1 to 16.
// (R04) Output divider divides by 1 to 16.
// (R05) Halt divider acts only in halt mode.
// (R06) Option gates internal clock onto output pin.
// (R07) Odd output ratio: high phase one input period.
// (R08) Reset out of stop loses prior state.
// (R09) Wake pin release keeps state and resumes.
// (R10) Option decides if wake pin releases stop.
// (R11) Shared pin interrupts outside stop only.
// (R12) Pin variant: multiplier from three pins, 1-8.
// (R13) Two select pins double as port bits.
// (R14) Pin variant fixes ratios at 1 and 8.
// (R15) Select pins stable before PLL initialisation.
// (R16) Pin variant always enables clock out, wake.
// (R17) Stop command enters the stop mode.
// (R18) Stop halts every clock, multiplier included.
// (R19) Halt ratio switches only on clock boundaries.
//
// Design decisions made here: the register offsets and the APB register port.
`timescale 1ns/100ps
module dccw_top
  import dccw_pkg::*;
#(
  parameter bit PIN_CONFIG = 1'b0,
  parameter int CNT_W      = 16
)(
  input  wire logic        core_clk,
  input  wire logic        srst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        ext_clk_in,
  input  wire logic        stop_release_n,
  input  wire logic        multiplier_select_bit0,
  input  wire logic        multiplier_select_bit1,
  input  wire logic        multiplier_select_bit2,
  output logic             general_port_bit_two,
  output logic             general_port_bit_three,
  output logic             sys_clk_tick,
  output logic             system_clock_output_pin,
  output logic             int_four_req,
  output logic             stop_resume_pulse,
  output logic             pll_locked
);

  // ==========================================================================
  // State and wires
  dccw_mode_t              state_ff;
  dccw_mode_t              nxt_state;
  logic [DCCW_CTRL_W-1:0]  ctrl_ff;
  logic [2:0]              pin_mult_ff;
  logic [31:0]             rdata_ff;
  logic                    system_clock_output_pin_ff;
  logic                    resume_ff;
  logic                    port2_ff;
  logic                    port3_ff;

  logic                    setup_ph;
  logic                    access_ph;
  logic                    mapped;
  logic                    wr_ctrl;
  logic                    stop_cmd;
  logic [31:0]             rd_value;
  logic                    stopped;
  logic                    halted;
  logic                    halt_want;
  logic                    wake_en_eff;
  logic                    system_clock_output_pin_en_eff;
  logic                    port_sel;
  logic                    wake_release;
  logic [3:0]              eff_m_m1;
  logic [3:0]              eff_n_m1;
  logic [3:0]              eff_l_m1;
  logic [2:0]              pin_mult_now;

  dccw_clk_if              pll_clk ();
  dccw_clk_if              norm_clk ();
  dccw_clk_if              halt_clk ();

  // ==========================================================================
  // Address decoding, used for both reads and writes
  function automatic logic dccw_is_mapped(input logic [7:0] addr);
    dccw_is_mapped = (addr == DCCW_OFS_CTRL) || (addr == DCCW_OFS_CMD) ||
                     (addr == DCCW_OFS_STAT);
  endfunction

  assign setup_ph  = psel & ~penable;
  assign access_ph = psel & penable;
  assign mapped    = dccw_is_mapped(paddr);
  assign pready    = 1'b1;
  assign pslverr   = access_ph & ~mapped;
  assign prdata    = rdata_ff;
  assign wr_ctrl   = access_ph & pwrite & (paddr == DCCW_OFS_CTRL);
  assign stop_cmd  = access_ph & pwrite & (paddr == DCCW_OFS_CMD) &
                     pwdata[DCCW_CMD_STOP];

  // ==========================================================================
  // Effective configuration; the pin variant overrides the option bits
  assign port_sel      = ctrl_ff[DCCW_CTRL_PORTSEL];
  assign pin_mult_now  = {multiplier_select_bit2,
                          port_sel & multiplier_select_bit1,
                          port_sel & multiplier_select_bit0}; // R13
  assign eff_m_m1      = PIN_CONFIG ? {1'b0, pin_mult_ff} :
                         ctrl_ff[DCCW_CTRL_M_LSB +: 4]; // R12 R03
  assign eff_n_m1      = PIN_CONFIG ? DCCW_PIN_N_M1 : ctrl_ff[DCCW_CTRL_N_LSB +: 4]; // R14
  assign eff_l_m1      = PIN_CONFIG ? DCCW_PIN_L_M1 : ctrl_ff[DCCW_CTRL_L_LSB +: 4]; // R14
  assign system_clock_output_pin_en_eff = PIN_CONFIG | ctrl_ff[DCCW_CTRL_SYSTEM_CLOCK_OUTPUT_PIN]; // R16 R06
  assign wake_en_eff   = PIN_CONFIG | ctrl_ff[DCCW_CTRL_WAKE]; // R16 R10
  assign halt_want     = ctrl_ff[DCCW_CTRL_HALT];

  // Port bits see the shared pins only while they are not select inputs.
  assign general_port_bit_two   = port2_ff;
  assign general_port_bit_three = port3_ff;

  // ==========================================================================
  // Mode control
  assign stopped      = (state_ff == DCCW_STOP);
  assign halted       = (state_ff == DCCW_HALT);
  assign wake_release = stopped & ~stop_release_n & wake_en_eff; // R09 R10
  assign int_four_req = ~stop_release_n & ~stopped; // R11

  always_comb
  begin
    nxt_state = state_ff;
    unique case (state_ff)
      DCCW_RUN:
        if (stop_cmd)
          nxt_state = DCCW_STOP; // R17
        else if (halt_want && norm_clk.tick)
          nxt_state = DCCW_HALT; // R19
      DCCW_HALT:
        if (stop_cmd)
          nxt_state = DCCW_STOP; // R17
        else if (!halt_want && halt_clk.tick)
          nxt_state = DCCW_RUN; // R19
      DCCW_STOP:
        if (wake_release)
          nxt_state = DCCW_RUN; // R09
      default:
        nxt_state = DCCW_RUN;
    endcase
  end

  // Reset clears every state register, so a reset out of stop starts afresh.
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      state_ff  <= DCCW_RUN; // R08
      resume_ff <= 1'b0;
    end
    else
    begin
      state_ff  <= nxt_state;
      resume_ff <= wake_release; // R09
    end
  end

  assign stop_resume_pulse = resume_ff;

  // ==========================================================================
  // Registers
  always_ff @(posedge core_clk)
  begin
    if (srst)
      ctrl_ff <= DCCW_CTRL_RST;
    else if (wr_ctrl)
      ctrl_ff <= pwdata[DCCW_CTRL_W-1:0];
  end

  // Select pins are sampled only in initialisation mode, so they must settle first.
  always_ff @(posedge core_clk)
  begin
    if (srst)
      pin_mult_ff <= DCCW_PIN_MULT_RST;
    else if (ctrl_ff[DCCW_CTRL_INIT])
      pin_mult_ff <= pin_mult_now; // R12 R15
  end

  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      port2_ff <= 1'b0;
      port3_ff <= 1'b0;
    end
    else
    begin
      port2_ff <= ~port_sel & multiplier_select_bit0; // R13
      port3_ff <= ~port_sel & multiplier_select_bit1; // R13
    end
  end

  always_comb
  begin
    rd_value = 32'h0000_0000;
    if (paddr == DCCW_OFS_CTRL)
      rd_value[DCCW_CTRL_W-1:0] = ctrl_ff;
    else if (paddr == DCCW_OFS_STAT)
    begin
      rd_value[DCCW_ST_STOP]             = stopped;
      rd_value[DCCW_ST_HALT]             = halted;
      rd_value[DCCW_ST_LOCK]             = pll_locked;
      rd_value[DCCW_ST_MULT_LSB +: 3]    = eff_m_m1[2:0];
      rd_value[DCCW_ST_PORT2]            = port2_ff;
      rd_value[DCCW_ST_PORT3]            = port3_ff;
    end
  end

  // Read data is captured in the setup phase and stands through the access.
  always_ff @(posedge core_clk)
  begin
    if (srst)
      rdata_ff <= 32'h0000_0000;
    else if (setup_ph)
      rdata_ff <= rd_value;
  end

  // ==========================================================================
  // Clock chain: multiplier, output divider, halt divider
  dccw_pll_rate #(
    .CNT_W    (CNT_W)
  ) u_pll (
    .core_clk (core_clk),
    .srst     (srst),
    .ext_clk_in (ext_clk_in),
    .stopped  (stopped), // R18
    .mult_m1  (eff_m_m1),
    .locked   (pll_locked),
    .pll_out  (pll_clk)
  );

  dccw_divider u_out_div (
    .core_clk (core_clk),
    .srst     (srst),
    .freeze   (stopped), // R18
    .bypass   (1'b0),
    .ratio_m1 (eff_n_m1),
    .div_in   (pll_clk),
    .div_out  (norm_clk)
  );

  dccw_divider u_halt_div (
    .core_clk (core_clk),
    .srst     (srst),
    .freeze   (stopped),
    .bypass   (~halted), // R05
    .ratio_m1 (eff_l_m1),
    .div_in   (norm_clk),
    .div_out  (halt_clk)
  );

  // The halt stage passes the normal clock through outside halt mode.
  assign sys_clk_tick = halt_clk.tick & ~stopped; // R01 R02 R18

  // Registered so the pin never shows a combinational glitch.
  always_ff @(posedge core_clk)
  begin
    if (srst)
      system_clock_output_pin_ff <= 1'b0;
    else
      system_clock_output_pin_ff <= system_clock_output_pin_en_eff & ~stopped & halt_clk.level; // R06
  end

  assign system_clock_output_pin = system_clock_output_pin_ff;

  // ==========================================================================
  // Checks
  sequence s_stop_written;
    stop_cmd ##1 stopped;
  endsequence

  a_stop_entry: assert property (@(posedge core_clk) disable iff (srst) // R17
    stop_cmd |-> s_stop_written)
    else $error("stop command did not enter stop mode");

  a_stop_no_tick: assert property (@(posedge core_clk) disable iff (srst) // R18
    stopped |-> !sys_clk_tick ##1 (!system_clock_output_pin || !stopped))
    else $error("clock ran during stop mode");

  sequence s_wake_seen;
    stopped && !stop_release_n && wake_en_eff;
  endsequence

  a_wake_release: assert property (@(posedge core_clk) disable iff (srst) // R09
    s_wake_seen |=> !stopped && stop_resume_pulse ##1 !stop_resume_pulse)
    else $error("wake pin did not release stop mode");

  a_wake_blocked: assert property (@(posedge core_clk) disable iff (srst) // R10
    (stopped && !wake_en_eff && !stop_cmd) |=> stopped)
    else $error("stop released with wake function disabled");

  a_int_in_stop: assert property (@(posedge core_clk) disable iff (srst) // R11
    (!stop_release_n) |-> (int_four_req != stopped))
    else $error("shared pin interrupt wrong for mode");

  a_halt_boundary: assert property (@(posedge core_clk) disable iff (srst) // R19
    (halted != $past(halted) && !$past(stopped) && !stopped) |->
      ($past(norm_clk.tick) || $past(halt_clk.tick)))
    else $error("halt ratio switched off a clock boundary");

  a_system_clock_output_pin_off: assert property (@(posedge core_clk) disable iff (srst) // R06
    (!system_clock_output_pin_en_eff && !wr_ctrl) |=> !system_clock_output_pin)
    else $error("clock output pin driven while disabled");

  a_pin_ratios: assert property (@(posedge core_clk) disable iff (srst) // R14
    PIN_CONFIG |-> (eff_n_m1 == 4'h0 && eff_l_m1 == 4'h7 && system_clock_output_pin_en_eff && wake_en_eff))
    else $error("pin variant ratios or enables not fixed");

  a_pin_sample: assert property (@(posedge core_clk) disable iff (srst) // R12
    (PIN_CONFIG && ctrl_ff[DCCW_CTRL_INIT]) |=> eff_m_m1 == {1'b0, $past(pin_mult_now)})
    else $error("multiplier not taken from select pins");

  a_halt_pass: assert property (@(posedge core_clk) disable iff (srst) // R05
    (state_ff == DCCW_RUN) |-> (halt_clk.tick == norm_clk.tick))
    else $error("halt divider acted outside halt mode");

endmodule

// ==== testbench/dccw_ext_model.sv ====
// Purpose: Far side model: reference clock, wake pin and select pins.
// Assumes: Everything moves just after a core_clk rising edge.
// Notes:   The wake pin has a pull-up, so a released pin reads high.
`timescale 1ns/100ps
module dccw_ext_model #(
  parameter int HALF = 20
)(
  input  wire logic       core_clk,
  input  wire logic       wake_req,
  input  wire logic       hold_sel,
  input  wire logic [2:0] sel_req,
  output logic            ext_clk_in,
  output logic            stop_release_n,
  output logic [2:0]      sel_pins
);
  // ========
  // Reference clock and strap pins
  int unsigned half_ff = 0;

  initial ext_clk_in = 1'b0;
  initial sel_pins = 3'h0;

  // The crystal runs free, so the reference never pauses.
  always @(posedge core_clk)
  begin
    half_ff <= (half_ff == HALF - 1) ? 0 : half_ff + 1;
    if (half_ff == HALF - 1)
      ext_clk_in <= ~ext_clk_in;
    if (!hold_sel)
      sel_pins <= sel_req;
  end

  assign stop_release_n = ~wake_req;
endmodule

// ==== testbench/tb_top.sv ====
// Purpose: Self-checking bench for the clock and wake-up control block.
// Assumes: A reference period of 40 core cycles, slow enough for m=16.
// Notes:   Tick counts allow one tick of slack for the divider phase.
`timescale 1ns/100ps
module tb_top
  import dccw_pkg::*;
;
  // ========
  // Signals
  localparam int HALF = 20;
  localparam int PER  = 2 * HALF;
  logic        core_clk = 1'b0;
  logic        srst     = 1'b1;
  logic [1:0]  psel_v   = 2'b00;
  logic        penable  = 1'b0;
  logic        pwrite   = 1'b0;
  logic [7:0]  paddr    = 8'h00;
  logic [31:0] pwdata   = 32'h0;
  logic        wake_req = 1'b0;
  logic        hold_sel = 1'b0;
  logic [2:0]  sel_req  = 3'h0;
  logic        cnt_on   = 1'b0;
  wire  [31:0] rdat [2];
  logic [31:0] c;
  wire  [1:0]  rdy, err, tick, pin, irq, res, lck, port2, port3;
  logic        ext_clk_in, stop_release_n, perr;
  logic [2:0]  sel_pins;
  int          failures = 0;
  int          samples_checked = 0;
  int          dev = 0;
  int          n_tick, n_high, n_int, n_res;
  int          tc [8][7] = '{'{1, 1, 1, 0, 1, 32, 4}, '{16, 1, 1, 0, 1, 512, 45},
    '{16, 16, 1, 0, 1, 640, 45}, '{16, 1, 16, 1, 1, 0, -1}, '{12, 3, 2, 1, 1, 0, -1},
    '{4, 2, 1, 0, 0, 0, 0}, '{3, 3, 1, 0, 1, 427, 45}, '{1, 2, 1, 0, 1, 640, 45}};

  always #20 core_clk = ~core_clk;

  // ========
  // Design and far side
  for (genvar g = 0; g < 2; g++)
  begin : g_dev
    dccw_top #(.PIN_CONFIG(1'(g))) u_dccw_top (
      .core_clk(core_clk), .srst(srst), .psel(psel_v[g]), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(rdat[g]),
      .pready(rdy[g]), .pslverr(err[g]), .ext_clk_in(ext_clk_in),
      .stop_release_n(stop_release_n), .multiplier_select_bit0(sel_pins[0]),
      .multiplier_select_bit1(sel_pins[1]), .multiplier_select_bit2(sel_pins[2]),
      .general_port_bit_two(port2[g]), .general_port_bit_three(port3[g]),
      .sys_clk_tick(tick[g]), .system_clock_output_pin(pin[g]),
      .int_four_req(irq[g]), .stop_resume_pulse(res[g]), .pll_locked(lck[g]));
  end

  dccw_ext_model #(.HALF(HALF)) u_dccw_ext_model (
    .core_clk(core_clk), .wake_req(wake_req), .hold_sel(hold_sel), .sel_req(sel_req),
    .ext_clk_in(ext_clk_in), .stop_release_n(stop_release_n), .sel_pins(sel_pins));

  // Counting on the rising edge sees the value settled over the cycle before.
  always @(posedge core_clk)
  begin
    if (cnt_on)
    begin
      chk(32'($isunknown({tick[dev], pin[dev], irq[dev], res[dev]})), 32'h0);
      n_tick += tick[dev];
      n_high += pin[dev];
      n_int  += irq[dev];
      n_res  += res[dev];
    end
  end

  // ========
  // Tasks
  task automatic report_and_stop;
    if (failures == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      failures++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic near(input int got, input int exp, input int tol);
    chk((got >= exp - tol && got <= exp + tol) ? exp : got, exp);
  endtask

  task automatic apb(input int d, input logic wr_en, input logic [7:0] a,
                     input logic [31:0] wd, output logic [31:0] rd);
    @(posedge core_clk);
    psel_v[d] <= 1'b1;
    pwrite    <= wr_en;
    paddr     <= a;
    pwdata    <= wd;
    @(posedge core_clk);
    penable <= 1'b1;
    @(posedge core_clk);
    while (rdy[d] !== 1'b1)
      @(posedge core_clk);
    rd   = rdat[d];
    perr = err[d];
    psel_v  <= 2'b00;
    penable <= 1'b0;
  endtask

  task automatic wr(input int d, input logic [7:0] a, input logic [31:0] v);
    logic [31:0] x;
    apb(d, 1'b1, a, v, x);
  endtask

  task automatic rdc(input int d, input logic [7:0] a, input logic [31:0] m,
                     input logic [31:0] e);
    logic [31:0] x;
    apb(d, 1'b0, a, 32'h0, x);
    chk(x & m, e);
  endtask

  function automatic logic [31:0] cv(input int m, input int n, input int l,
                                     input int ck, input int wk, input int hl);
    return 32'(m - 1) | 32'(n - 1) << DCCW_CTRL_N_LSB | 32'(l - 1) << DCCW_CTRL_L_LSB
         | 32'(ck) << DCCW_CTRL_SYSTEM_CLOCK_OUTPUT_PIN | 32'(wk) << DCCW_CTRL_WAKE
         | 32'(hl) << DCCW_CTRL_HALT;
  endfunction

  task automatic win(input int cyc);
    @(negedge core_clk);
    {n_tick, n_high, n_int, n_res} = '0;
    cnt_on = 1'b1;
    repeat (cyc) @(negedge core_clk);
    cnt_on = 1'b0;
  endtask

  // A negative tolerance skips the clock pin count.
  task automatic meas(input int d, input int t, input int eh, input int th);
    dev = d;
    @(posedge ext_clk_in);
    win(32 * PER);
    near(n_tick, t, 1);
    if (th >= 0)
      near(n_high, eh, th);
  endtask

  task automatic wake_low(input int n);
    @(posedge core_clk);
    wake_req <= 1'b1;
    repeat (n) @(posedge core_clk);
    wake_req <= 1'b0;
  endtask

  task automatic rst;
    @(posedge core_clk);
    srst <= 1'b1;
    repeat (16) @(posedge core_clk);
    srst <= 1'b0;
  endtask

  // ========
  // Tests
  initial
  begin
    repeat (60000) @(posedge core_clk);
    failures++;
    report_and_stop();
  end

  initial
  begin
    rst();
    rdc(0, DCCW_OFS_CTRL, '1, 32'(DCCW_CTRL_RST));
    rdc(0, DCCW_OFS_CMD, '1, 32'h0);
    rdc(0, 8'h0c, '1, 32'h0);
    chk(32'(perr), 32'h1);
    c = 32'(DCCW_CTRL_RST);
    // Halt is dropped first so that l only changes while its divider is bypassed.
    for (int i = 0; i < 8; i++)
    begin
      wr(0, DCCW_OFS_CTRL, c & ~32'h4000);
      repeat (2 * PER) @(posedge core_clk);
      c = cv(tc[i][0], tc[i][1], tc[i][2], tc[i][4], 1, tc[i][3]);
      wr(0, DCCW_OFS_CTRL, c & ~32'h4000);
      wr(0, DCCW_OFS_CTRL, c);
      repeat (4 * PER) @(posedge core_clk);
      rdc(0, DCCW_OFS_CTRL, '1, c);
      rdc(0, DCCW_OFS_STAT, 32'h77, 32'(tc[i][3] * 2 + 4 + ((tc[i][0] - 1) % 8) * 16));
      meas(0, 32 * tc[i][0] / (tc[i][1] * tc[i][2]), tc[i][5], tc[i][6]);
    end
    chk(32'(lck), 32'h3);
    wr(0, DCCW_OFS_CTRL, cv(4, 2, 1, 1, 0, 0));
    repeat (4 * PER) @(posedge core_clk);
    wr(0, DCCW_OFS_CMD, 32'h1);
    rdc(0, DCCW_OFS_STAT, 32'h1, 32'h1);
    fork
      win(40);
      wake_low(10);
    join
    chk(n_tick + n_high + n_res + n_int, 0);
    rdc(0, DCCW_OFS_STAT, 32'h1, 32'h1);
    rst();
    rdc(0, DCCW_OFS_CTRL, '1, 32'(DCCW_CTRL_RST));
    rdc(0, DCCW_OFS_STAT, 32'h1, 32'h0);
    c = cv(5, 1, 1, 1, 1, 0);
    wr(0, DCCW_OFS_CTRL, c);
    repeat (4 * PER) @(posedge core_clk);
    wr(0, DCCW_OFS_CMD, 32'h1);
    fork
      win(20);
      wake_low(10);
    join
    chk(n_res, 1);
    chk(n_int, 9);
    rdc(0, DCCW_OFS_CTRL, '1, c);
    meas(0, 160, 0, -1);
    fork
      win(20);
      wake_low(10);
    join
    chk(n_int, 10);
    chk(n_res, 0);
    sel_req <= 3'b101;
    repeat (4) @(posedge core_clk);
    hold_sel <= 1'b1;
    wr(1, DCCW_OFS_CTRL, 32'h18000);
    wr(1, DCCW_OFS_CTRL, 32'h08030);
    hold_sel <= 1'b0;
    sel_req  <= 3'b010;
    repeat (4 * PER) @(posedge core_clk);
    rdc(1, DCCW_OFS_STAT, 32'h377, 32'h054);
    meas(1, 192, 192, 45);
    wr(1, DCCW_OFS_CTRL, 32'h0c030);
    repeat (4 * PER) @(posedge core_clk);
    meas(1, 24, 0, -1);
    wr(1, DCCW_OFS_CTRL, 32'h00030);
    sel_req <= 3'b111;
    repeat (4) @(posedge core_clk);
    hold_sel <= 1'b1;
    wr(1, DCCW_OFS_CTRL, 32'h10000);
    wr(1, DCCW_OFS_CTRL, 32'h00000);
    hold_sel <= 1'b0;
    rdc(1, DCCW_OFS_STAT, 32'h370, 32'h340);
    chk(32'({port3[1], port2[1]}), 32'h3);
    wr(1, DCCW_OFS_CMD, 32'h1);
    fork
      win(20);
      wake_low(10);
    join
    chk(n_res, 1);
    report_and_stop();
  end
endmodule
